// ==== csg_clock_ctrl.sv ====
// csg_clock_ctrl.sv: clock source control, divider, ready flags and write guard
// assumes: avalon-mm slave with word addresses; oscillator levels arrive asynchronously
// Functional notes
// - ulp oscillator yields a 1 kHz tick for rtc, watchdog and brownout detector.
// - ulp ready only after analog start-up plus four own oscillator cycles.
// - input select bit picks crystal across both pins or 32 kHz clock on pin in.
// - crystal enable set hands both crystal pins from gpio to the oscillator.
// - crystal oscillator starts on request only while its enable bit is set.
// - crystal start-up select field sets the crystal readiness delay.
// - external-clock mode of crystal oscillator fixes start-up at two input cycles.
// - pin clock taken directly; its gpio set to clock input when requested.
// - pin clock reports started after two input cycles from first request.
// - guarded writes without a valid unlock are ignored, contents unchanged.
// - guard covers main control, divider, lock, crystal, fast ctrl, trims, ulp ctrl.
// - two-bit source select: fast, ulp, crystal, pin clock.
// - divider off passes main clock; on selects 2..64 or 6..48 by code.
// - lock bit blocks main control, divider and, while the fast source is active, trim updates until reset.
// - switching flag stays set until the new source is stable.
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "csg_map.svh"
module csg_clock_ctrl #(
  parameter logic [15:0] XTAL_CSUT0 = 16'h0100,
  parameter logic [15:0] XTAL_CSUT1 = 16'h0400,
  parameter logic [15:0] XTAL_CSUT2 = 16'h1000,
  parameter logic [15:0] XTAL_CSUT3 = 16'h4000,
  parameter logic        LOCK_FUSE  = 1'b0
) (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_instr_retired,
  input  wire logic        i_periph_req_xtal,
  input  wire logic        i_periph_req_pin,
  input  wire logic        i_periph_req_ulp,
  input  wire logic        i_ulp_osc,
  input  wire logic        i_ulp_analog_up,
  input  wire logic        i_fast_rc_up,
  input  wire logic        i_crystal_osc,
  input  wire logic        i_crystal_pin_in,
  input  wire logic        i_ext_pin_clock,
  output logic             o_crystal_pins_own,
  output logic             o_crystal_drive_en,
  output logic             o_ext_pin_clock_input,
  output logic             o_clock_output_pin_enable,
  output logic [1:0]       o_main_source,
  output logic [6:0]       o_periph_div,
  output logic             o_ulp_tick,
  output logic [7:0]       o_fast_osc_trim,
  output logic [3:0]       o_fast_osc_temp_trim
);
  logic [7:0] main_src_r, div_ctrl_r, lock_r, fast_ctrl_r;
  logic [7:0] trim_a_r, trim_b_r, lp_ctrl_r, xtal_ctrl_r;
  logic [2:0] window_r;
  logic       lock_caught_r;
  logic       acc_done_r;
  logic [1:0] active_src_r;
  logic       switching_r;
  logic       ulp_a1_r, ulp_a2_r, fast_a1_r, fast_a2_r;
  logic [15:0] xtal_cnt_r;
  logic       xtal_ok_r;
  csg_pkg::csg_ready_s ready;
  logic       ulp_done, pin_done, xosc_ext_done, osc_edge_done;
  logic       xtal_req, pin_req, ulp_req, fast_req;
  logic       guarded, lockable, wr_ok, wr_fire, rd_fire;
  logic [7:0] idx, wdata, rdata;
  logic [15:0] crystal_startup_select_cnt;
  logic [6:0] div_nxt;

  assign idx     = i_avs_address;
  assign wdata   = i_avs_writedata[7:0];
  assign wr_fire = i_avs_write && !acc_done_r;
  assign rd_fire = i_avs_read && !acc_done_r;

  // one wait cycle per access, answered on the second edge
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acc_done_r        <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= '0;
    end else begin
      acc_done_r        <= (i_avs_read || i_avs_write) && !acc_done_r;
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !acc_done_r);
      o_avs_readdata    <= rd_fire ? {24'h000000, rdata} : 32'h00000000;
    end
  end

  always_comb begin
    guarded = 1'b0;
    unique case (idx)
      `CSG_IDX_MAIN_SRC, `CSG_IDX_DIV_CTRL, `CSG_IDX_LOCK, `CSG_IDX_FAST_CTRL,
      `CSG_IDX_TRIM_A, `CSG_IDX_TRIM_B, `CSG_IDX_LP_CTRL, `CSG_IDX_XTAL_CTRL:
        guarded = 1'b1;
      default: guarded = 1'b0;
    endcase
  end

  // lock covers main control, divider, lock itself and trims of the fast source while it is the active source
  assign lockable = (idx == `CSG_IDX_MAIN_SRC) || (idx == `CSG_IDX_DIV_CTRL) ||
                    (idx == `CSG_IDX_LOCK) ||
                    (((idx == `CSG_IDX_TRIM_A) || (idx == `CSG_IDX_TRIM_B)) &&
                     (active_src_r == 2'(csg_pkg::CSG_SRC_FAST)));
  assign wr_ok = wr_fire && (window_r != 3'h0) && !(lock_r[0] && lockable);

  // unlock window: key arms, retired instructions count down
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      window_r <= 3'h0;
    end else if (wr_fire && idx == `CSG_IDX_GUARD && wdata == `CSG_KEY_IO_REGISTER_KEY) begin
      window_r <= `CSG_UNLOCK_INSTR;
    end else if (window_r != 3'h0 && (i_instr_retired ||
                 (wr_fire && idx == `CSG_IDX_INSTR))) begin
      window_r <= window_r - 3'h1;
    end
  end

  // lock bit takes the fuse level after release
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lock_caught_r <= 1'b0;
      lock_r        <= `CSG_RST_OTHER;
    end else if (!lock_caught_r) begin
      lock_caught_r <= 1'b1;
      lock_r        <= {7'h00, LOCK_FUSE};
    end else if (wr_ok && idx == `CSG_IDX_LOCK && wdata[0]) begin
      lock_r <= 8'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      main_src_r  <= `CSG_RST_MAIN_SRC;
      div_ctrl_r  <= `CSG_RST_DIV_CTRL;
      fast_ctrl_r <= `CSG_RST_OTHER;
      trim_a_r    <= `CSG_RST_OTHER;
      trim_b_r    <= `CSG_RST_OTHER;
      lp_ctrl_r   <= `CSG_RST_OTHER;
      xtal_ctrl_r <= `CSG_RST_OTHER;
    end else if (wr_ok && guarded) begin
      unique case (idx)
        `CSG_IDX_MAIN_SRC: if (!switching_r) main_src_r <= wdata & 8'h83;
        `CSG_IDX_DIV_CTRL: div_ctrl_r  <= wdata & 8'h1f;
        `CSG_IDX_FAST_CTRL: fast_ctrl_r <= wdata & 8'h02;
        `CSG_IDX_TRIM_A:   trim_a_r    <= wdata & 8'h7f;
        `CSG_IDX_TRIM_B:   trim_b_r    <= wdata & 8'h8f;
        `CSG_IDX_LP_CTRL:  lp_ctrl_r   <= wdata & 8'h02;
        `CSG_IDX_XTAL_CTRL: xtal_ctrl_r <= wdata & 8'h37;
        default: ;
      endcase
    end
  end

  // requests
  assign xtal_req = xtal_ctrl_r[`CSG_XTAL_ENABLE] && (i_periph_req_xtal ||
                    xtal_ctrl_r[`CSG_XTAL_KEEP_RUNNING_IN_STANDBY] ||
                    main_src_r[1:0] == 2'(csg_pkg::CSG_SRC_XTAL));
  assign pin_req  = i_periph_req_pin || main_src_r[1:0] == 2'(csg_pkg::CSG_SRC_PIN);
  assign ulp_req  = i_periph_req_ulp || lp_ctrl_r[1] ||
                    main_src_r[1:0] == 2'(csg_pkg::CSG_SRC_ULP);
  assign fast_req = fast_ctrl_r[1] || main_src_r[1:0] == 2'(csg_pkg::CSG_SRC_FAST) ||
                    active_src_r == 2'(csg_pkg::CSG_SRC_FAST);

  // analog start-up levels
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ulp_a1_r  <= 1'b0;
      ulp_a2_r  <= 1'b0;
      fast_a1_r <= 1'b0;
      fast_a2_r <= 1'b0;
    end else begin
      ulp_a1_r  <= i_ulp_analog_up;
      ulp_a2_r  <= ulp_a1_r;
      fast_a1_r <= i_fast_rc_up;
      fast_a2_r <= fast_a1_r;
    end
  end

  csg_edge_counter #(.W(3)) u_ulp_start (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_run    (ulp_req && ulp_a2_r),
    .i_clk_in (i_ulp_osc),
    .i_target (3'(`CSG_ULP_EXTRA_CYC)),
    .o_done   (ulp_done)
  );

  csg_edge_counter #(.W(2)) u_pin_start (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_run    (pin_req),
    .i_clk_in (i_ext_pin_clock),
    .i_target (2'(`CSG_PIN_START_CYC)),
    .o_done   (pin_done)
  );

  csg_edge_counter #(.W(2)) u_xosc_ext (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_run    (xtal_req && xtal_ctrl_r[`CSG_XTAL_SEL]),
    .i_clk_in (i_crystal_pin_in),
    .i_target (2'(`CSG_PIN_START_CYC)),
    .o_done   (xosc_ext_done)
  );

  csg_edge_counter #(.W(1)) u_xosc_osc (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_run    (xtal_req && !xtal_ctrl_r[`CSG_XTAL_SEL]),
    .i_clk_in (i_crystal_osc),
    .i_target (1'h1),
    .o_done   (osc_edge_done)
  );

  always_comb begin
    unique case (xtal_ctrl_r[5:4])
      2'h0: crystal_startup_select_cnt = XTAL_CSUT0;
      2'h1: crystal_startup_select_cnt = XTAL_CSUT1;
      2'h2: crystal_startup_select_cnt = XTAL_CSUT2;
      default: crystal_startup_select_cnt = XTAL_CSUT3;
    endcase
  end

  // crystal readiness after selected start-up count
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      xtal_cnt_r <= '0;
      xtal_ok_r  <= 1'b0;
    end else if (!xtal_req || xtal_ctrl_r[`CSG_XTAL_SEL] || !osc_edge_done) begin
      xtal_cnt_r <= '0;
      xtal_ok_r  <= 1'b0;
    end else if (!xtal_ok_r) begin
      xtal_cnt_r <= xtal_cnt_r + 16'h0001;
      xtal_ok_r  <= (xtal_cnt_r + 16'h0001) >= crystal_startup_select_cnt;
    end
  end

  assign ready.pin_started    = pin_done;
  assign ready.crystal_stable = xtal_ctrl_r[`CSG_XTAL_SEL] ? xosc_ext_done : xtal_ok_r;
  assign ready.ulp_stable     = ulp_done;
  assign ready.fast_rc_stable = fast_req && fast_a2_r;

  // source switch: hold the switching flag until the target is ready
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      active_src_r <= 2'(csg_pkg::CSG_SRC_FAST);
      switching_r  <= 1'b0;
    end else if (main_src_r[1:0] != active_src_r) begin
      switching_r <= 1'b1;
      if (ready[main_src_r[1:0]]) begin
        active_src_r <= main_src_r[1:0];
        switching_r  <= 1'b0;
      end
    end else begin
      switching_r <= 1'b0;
    end
  end

  always_comb begin
    div_nxt = 7'h01;
    if (div_ctrl_r[0]) begin
      unique case (div_ctrl_r[4:1])
        4'h0: div_nxt = 7'h02;
        4'h1: div_nxt = 7'h04;
        4'h2: div_nxt = 7'h08;
        4'h3: div_nxt = 7'h10;
        4'h4: div_nxt = 7'h20;
        4'h5: div_nxt = 7'h40;
        4'h8: div_nxt = 7'h06;
        4'h9: div_nxt = 7'h0a;
        4'ha: div_nxt = 7'h0c;
        4'hb: div_nxt = 7'h18;
        4'hc: div_nxt = 7'h30;
        default: div_nxt = 7'h01;
      endcase
    end
  end

  always_comb begin
    rdata = 8'h00;
    unique case (idx)
      `CSG_IDX_MAIN_SRC:  rdata = main_src_r;
      `CSG_IDX_DIV_CTRL:  rdata = div_ctrl_r;
      `CSG_IDX_LOCK:      rdata = lock_r;
      `CSG_IDX_STATE:     rdata = {ready, 3'h0, switching_r};
      `CSG_IDX_FAST_CTRL: rdata = fast_ctrl_r;
      `CSG_IDX_TRIM_A:    rdata = trim_a_r;
      `CSG_IDX_TRIM_B:    rdata = trim_b_r;
      `CSG_IDX_LP_CTRL:   rdata = lp_ctrl_r;
      `CSG_IDX_XTAL_CTRL: rdata = xtal_ctrl_r;
      `CSG_IDX_INSTR:     rdata = {5'h00, window_r};
      default:            rdata = 8'h00;
    endcase
  end

  logic ulp_tick;
  csg_tick_gen u_tick (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_run    (ulp_done),
    .i_osc    (i_ulp_osc),
    .o_tick   (ulp_tick)
  );

  // registered outputs
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_crystal_pins_own        <= 1'b0;
      o_crystal_drive_en        <= 1'b0;
      o_ext_pin_clock_input     <= 1'b0;
      o_clock_output_pin_enable <= 1'b0;
      o_main_source             <= 2'h0;
      o_periph_div              <= 7'h01;
      o_ulp_tick                <= 1'b0;
      o_fast_osc_trim           <= 8'h00;
      o_fast_osc_temp_trim      <= 4'h0;
    end else begin
      o_crystal_pins_own        <= xtal_ctrl_r[`CSG_XTAL_ENABLE];
      o_crystal_drive_en        <= xtal_req && !xtal_ctrl_r[`CSG_XTAL_SEL];
      o_ext_pin_clock_input     <= pin_req;
      o_clock_output_pin_enable <= main_src_r[`CSG_MAIN_CLOCK_OUTPUT_PIN_ENABLE];
      o_main_source             <= active_src_r;
      o_periph_div              <= div_nxt;
      o_ulp_tick                <= ulp_tick;
      o_fast_osc_trim           <= trim_a_r;
      o_fast_osc_temp_trim      <= trim_b_r[3:0];
    end
  end
endmodule

// ==== csg_map.svh ====
// csg_map.svh: register offsets, field positions, reset values and timing counts
// assumes: included by bare name from design files
`ifndef CSG_MAP_SVH
`define CSG_MAP_SVH
// register indices (byte address = 4 * index)
`define CSG_IDX_MAIN_SRC    8'h00
`define CSG_IDX_DIV_CTRL    8'h01
`define CSG_IDX_LOCK        8'h02
`define CSG_IDX_STATE       8'h03
`define CSG_IDX_FAST_CTRL   8'h10
`define CSG_IDX_TRIM_A      8'h11
`define CSG_IDX_TRIM_B      8'h12
`define CSG_IDX_LP_CTRL     8'h18
`define CSG_IDX_XTAL_CTRL   8'h1c
`define CSG_IDX_GUARD       8'h20
`define CSG_IDX_INSTR       8'h21
// unlock key and window
`define CSG_KEY_IO_REGISTER_KEY       8'hd8
`define CSG_UNLOCK_INSTR    3'h4
// reset values
`define CSG_RST_MAIN_SRC    8'h00
`define CSG_RST_DIV_CTRL    8'h11
`define CSG_RST_OTHER       8'h00
// field positions
`define CSG_MAIN_CLOCK_OUTPUT_PIN_ENABLE     7
`define CSG_XTAL_ENABLE     0
`define CSG_XTAL_KEEP_RUNNING_IN_STANDBY   1
`define CSG_XTAL_SEL        2
`define CSG_XTAL_CRYSTAL_STARTUP_SELECT_LO    4
`define CSG_ST_EXT          7
`define CSG_ST_XTAL         6
`define CSG_ST_ULP          5
`define CSG_ST_FAST         4
`define CSG_ST_SWITCH       0
// timing
`define CSG_ULP_EXTRA_CYC   4
`define CSG_PIN_START_CYC   2
`define CSG_CLK_MHZ         100
`define CSG_TICK_HZ         1000
`define CSG_ULP_HZ          32768
`endif

// ==== csg_pkg.sv ====
// csg_pkg.sv: types shared by the clock source and write guard block
// assumes: used with explicit package scope, never imported
package csg_pkg;
  typedef enum logic [1:0] {
    CSG_SRC_FAST,
    CSG_SRC_ULP,
    CSG_SRC_XTAL,
    CSG_SRC_PIN
  } csg_src_e;

  // ready flags of every oscillator
  typedef struct packed {
    logic pin_started;
    logic crystal_stable;
    logic ulp_stable;
    logic fast_rc_stable;
  } csg_ready_s;
endpackage

// ==== csg_edge_counter.sv ====
// csg_edge_counter.sv: counts rising edges of a synchronised clock input
// assumes: i_clk_in is asynchronous; requires i_clk far faster than it
`timescale 1ns/1ps
module csg_edge_counter #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  input  wire logic         i_run,
  input  wire logic         i_clk_in,
  input  wire logic [W-1:0] i_target,
  output logic              o_done
);
  logic         s1_r;
  logic         s2_r;
  logic         s3_r;
  logic [W-1:0] cnt_r;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= i_clk_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r  <= '0;
      o_done <= 1'b0;
    end else if (!i_run) begin
      cnt_r  <= '0;
      o_done <= 1'b0;
    end else if (!o_done && s2_r && !s3_r) begin
      cnt_r  <= cnt_r + W'(1);
      o_done <= (cnt_r + W'(1)) >= i_target;
    end
  end
endmodule

// ==== csg_tick_gen.sv ====
// csg_tick_gen.sv: 1 kHz tick from the ulp oscillator, one pulse per period
// assumes: i_osc is the synchronised-free raw oscillator, sampled here
`timescale 1ns/1ps
`include "csg_map.svh"
module csg_tick_gen #(
  parameter int DIV = `CSG_ULP_HZ / `CSG_TICK_HZ
) (
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_run,
  input  wire logic i_osc,
  output logic      o_tick
);
  logic       s1_r;
  logic       s2_r;
  logic       s3_r;
  logic [5:0] cnt_r;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= i_osc;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r  <= '0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= 1'b0;
      if (!i_run) begin
        cnt_r <= '0;
      end else if (s2_r && !s3_r) begin
        if (cnt_r == 6'(DIV - 1)) begin
          cnt_r  <= '0;
          o_tick <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 6'h01;
        end
      end
    end
  end
endmodule

// ==== csg_clock_ctrl_asserts.sv ====
// csg_clock_ctrl_asserts.sv: port-level checks of the clock controller
// assumes: bound into csg_clock_ctrl, one clock domain
`timescale 1ns/1ps
module csg_clock_ctrl_chk (
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire logic [7:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_periph_req_pin,
  input wire logic        o_crystal_pins_own,
  input wire logic        o_crystal_drive_en,
  input wire logic        o_ext_pin_clock_input,
  input wire logic [6:0]  o_periph_div,
  input wire logic        o_ulp_tick
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire logic req;
  assign req = i_avs_read | i_avs_write;
  a_answer_next: assert property (req && o_avs_waitrequest && $past(o_avs_waitrequest)
    |=> !o_avs_waitrequest) else $error("access not answered one cycle later");
  a_no_spurious: assert property (!req && o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("answer without access");
  a_answer_once: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("answer held longer than one cycle");
  a_rdata_quiet: assert property (o_avs_waitrequest |-> o_avs_readdata == 32'h00000000)
    else $error("read data outside answer cycle");
  a_reserved_zero: assert property (
    i_avs_read && o_avs_waitrequest &&
    (i_avs_address inside {[8'h04:8'h0f], [8'h13:8'h17], [8'h19:8'h1b]})
    |=> o_avs_readdata == 32'h00000000) else $error("reserved place read nonzero");
  a_div_legal: assert property (
    o_periph_div inside {7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40,
                         7'h06, 7'h0a, 7'h0c, 7'h18, 7'h30})
    else $error("divide factor outside table");
  a_pins_cause: assert property ($changed(o_crystal_pins_own) |->
    $past(i_avs_write && o_avs_waitrequest && i_avs_address == 8'h1c, 2))
    else $error("crystal pins changed without crystal control write");
  a_drive_own: assert property (o_crystal_drive_en |-> o_crystal_pins_own)
    else $error("crystal driven while not enabled");
  a_pin_input: assert property ($rose(i_periph_req_pin) |-> ##[0:4] o_ext_pin_clock_input)
    else $error("pin not set as clock input on request");
  a_tick_pulse: assert property (o_ulp_tick |=> !o_ulp_tick)
    else $error("tick longer than one cycle");
endmodule
bind csg_clock_ctrl csg_clock_ctrl_chk u_chk (
  .i_clk, .i_arst_n, .i_avs_address, .i_avs_read, .i_avs_write, .o_avs_readdata,
  .o_avs_waitrequest, .i_periph_req_pin, .o_crystal_pins_own, .o_crystal_drive_en,
  .o_ext_pin_clock_input, .o_periph_div, .o_ulp_tick
);

// ==== csg_clk_src.sv ====
// csg_clk_src.sv: crystal pins and clock pin as driven from outside
// assumes: enables come from the device; clocks stand low while off
`timescale 1ns/1ps
module csg_clk_src #(
  parameter int HALF_NS = 100
) (
  input  wire logic i_pins_own,
  input  wire logic i_drive_en,
  input  wire logic i_pin_input,
  output logic      o_crystal_pin_in,
  output logic      o_crystal_osc,
  output logic      o_ext_pin_clock
);
  logic ph;
  initial begin
    ph = 1'b0;
    forever #(HALF_NS) ph = ~ph;
  end
  assign o_crystal_pin_in = i_pins_own & ph;
  assign o_crystal_osc    = i_drive_en & ph;
  assign o_ext_pin_clock  = i_pin_input & ph;
endmodule

// ==== csg_clock_ctrl_tb_top.sv ====
// csg_clock_ctrl_tb_top.sv: self-checking bench with a register model
// assumes: csg_clk_src on the far side; oscillators far slower than i_clk
`timescale 1ns/1ps
`include "csg_map.svh"
module csg_clock_ctrl_tb_top;
  logic        i_clk, i_arst_n, i_avs_read, i_avs_write, i_instr_retired, o_avs_waitrequest;
  logic        i_periph_req_xtal, i_periph_req_pin, i_periph_req_ulp, i_ulp_osc;
  logic        i_ulp_analog_up, i_fast_rc_up, i_crystal_osc, i_crystal_pin_in;
  logic        i_ext_pin_clock, o_crystal_pins_own, o_crystal_drive_en, o_ulp_tick;
  logic        o_ext_pin_clock_input, o_clock_output_pin_enable;
  logic [7:0]  i_avs_address, o_fast_osc_trim, d;
  logic [31:0] i_avs_writedata, o_avs_readdata;
  logic [1:0]  o_main_source;
  logic [6:0]  o_periph_div;
  logic [3:0]  o_fast_osc_temp_trim;
  int          errors, total_checks, win, lock, act, n, seed;
  int          mdl[int];
  int          dv[16] = '{2, 4, 8, 16, 32, 64, 0, 0, 6, 10, 12, 24, 48, 0, 0, 0};
  byte unsigned gidx[8] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h11, 8'h12, 8'h18, 8'h1c};
  byte unsigned gmsk[8] = '{8'h83, 8'h1f, 8'h01, 8'h02, 8'h7f, 8'h8f, 8'h02, 8'h37};
  byte unsigned rsv[6]  = '{8'h04, 8'h0f, 8'h13, 8'h17, 8'h19, 8'h1b};
  csg_clock_ctrl u_csg_clock_ctrl (
    .i_clk, .i_arst_n, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .o_avs_readdata, .o_avs_waitrequest, .i_instr_retired, .i_periph_req_xtal,
    .i_periph_req_pin, .i_periph_req_ulp, .i_ulp_osc, .i_ulp_analog_up, .i_fast_rc_up,
    .i_crystal_osc, .i_crystal_pin_in, .i_ext_pin_clock, .o_crystal_pins_own,
    .o_crystal_drive_en, .o_ext_pin_clock_input, .o_clock_output_pin_enable,
    .o_main_source, .o_periph_div, .o_ulp_tick, .o_fast_osc_trim, .o_fast_osc_temp_trim
  );
  csg_clk_src u_csg_clk_src (
    .i_pins_own(o_crystal_pins_own), .i_drive_en(o_crystal_drive_en),
    .i_pin_input(o_ext_pin_clock_input), .o_crystal_pin_in(i_crystal_pin_in),
    .o_crystal_osc(i_crystal_osc), .o_ext_pin_clock(i_ext_pin_clock)
  );
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    i_ulp_osc = 1'b0;
    forever #100 i_ulp_osc = ~i_ulp_osc;
  end
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(bit wr, logic [7:0] a, logic [7:0] dd, output logic [31:0] q);
    int k;
    k = 0;
    i_avs_address   <= a;
    i_avs_writedata <= {24'h000000, dd};
    i_avs_write     <= wr;
    i_avs_read      <= !wr;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    chk("bus wait", 2, k);
    i_avs_write <= 1'b0;
    i_avs_read  <= 1'b0;
    @(posedge i_clk);
  endtask
  // write through the bus and mirror it in the model
  task automatic wr(logic [7:0] a, logic [7:0] dd);
    logic [31:0] q;
    int k;
    bus(1'b1, a, dd, q);
    k = -1;
    foreach (gidx[i]) if (gidx[i] == a) k = i;
    if (a == `CSG_IDX_GUARD && dd == `CSG_KEY_IO_REGISTER_KEY) win = 4;
    else if (a == `CSG_IDX_INSTR) win = (win > 0) ? win - 1 : 0;
    else if (k >= 0 && win > 0 && !(lock != 0 && (a < 3 || (act == 0 && (a == 8'h11 ||
             a == 8'h12))))) mdl[a] = dd & gmsk[k];
    lock = mdl[2] & 1;
  endtask
  task automatic uwr(logic [7:0] a, logic [7:0] dd);
    wr(`CSG_IDX_GUARD, `CSG_KEY_IO_REGISTER_KEY);
    wr(a, dd);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic stat(int b, logic e);
    logic [31:0] q;
    bus(1'b0, `CSG_IDX_STATE, 8'h00, q);
    chk($sformatf("status bit %0d", b), {31'h0, e}, {31'h0, q[b]});
  endtask
  initial begin
    {i_avs_read, i_avs_write, i_instr_retired, i_periph_req_xtal, i_periph_req_pin} = '0;
    {i_periph_req_ulp, i_ulp_analog_up} = '0;
    i_fast_rc_up = 1'b1;
    i_avs_address = 8'h00;
    i_avs_writedata = 32'h00000000;
    i_arst_n = 1'b0;
    foreach (gidx[i]) mdl[gidx[i]] = 0;
    mdl[1] = 8'h11;
    seed = $urandom(30145);
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    foreach (gidx[i]) rd(gidx[i], mdl[gidx[i]]);
    chk("div reset", 6, o_periph_div);
    foreach (gidx[i]) begin
      wr(gidx[i], 8'($urandom));
      rd(gidx[i], mdl[gidx[i]]);
    end
    foreach (gidx[i]) if (gidx[i] > 8'h02) begin
      d = 8'($urandom);
      if (gidx[i] == 8'h12) d &= 8'h0f;
      uwr(gidx[i], d);
      rd(gidx[i], mdl[gidx[i]]);
    end
    uwr(8'h00, 8'h80);
    rd(8'h00, mdl[0]);
    chk("clock out", 1, o_clock_output_pin_enable);
    chk("trim", mdl[8'h11], o_fast_osc_trim);
    chk("temp trim", mdl[8'h12] & 15, o_fast_osc_temp_trim);
    chk("pins own", mdl[8'h1c] & 1, o_crystal_pins_own);
    for (int c = 0; c < 16; c++) if (dv[c] != 0) begin
      uwr(8'h01, 8'(c * 2 + 1));
      chk("div", dv[c], o_periph_div);
    end
    uwr(8'h01, 8'h10);
    chk("div off", 1, o_periph_div);
    wr(`CSG_IDX_GUARD, `CSG_KEY_IO_REGISTER_KEY);
    rd(`CSG_IDX_INSTR, 4);
    i_instr_retired <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_instr_retired <= 1'b0;
    win = 0;
    rd(`CSG_IDX_INSTR, 0);
    wr(8'h11, 8'h55);
    rd(8'h11, mdl[8'h11]);
    for (int m = 3; m < 5; m++) begin
      wr(`CSG_IDX_GUARD, `CSG_KEY_IO_REGISTER_KEY);
      repeat (m) wr(`CSG_IDX_INSTR, 8'h00);
      wr(8'h18, 8'(m == 3 ? 8'h02 : 8'h00));
      rd(8'h18, mdl[8'h18]);
    end
    foreach (rsv[i]) begin
      uwr(rsv[i], 8'hff);
      rd(rsv[i], 0);
    end
    i_periph_req_ulp <= 1'b1;
    repeat (400) @(posedge i_clk);
    stat(5, 1'b0);
    i_ulp_analog_up <= 1'b1;
    repeat (30) @(posedge i_clk);
    stat(5, 1'b0);
    repeat (200) @(posedge i_clk);
    stat(5, 1'b1);
    for (n = 0; n < 2000 && o_ulp_tick !== 1'b1; n++) @(posedge i_clk);
    for (n = 1; n < 2000; n++) begin
      @(posedge i_clk);
      if (o_ulp_tick === 1'b1) break;
    end
    chk("tick gap", 1, n >= 639 && n <= 641);
    uwr(8'h1c, 8'h04);
    i_periph_req_xtal <= 1'b1;
    repeat (100) @(posedge i_clk);
    stat(6, 1'b0);
    chk("pins idle", 0, o_crystal_pins_own);
    uwr(8'h1c, 8'h35);
    stat(6, 1'b0);
    repeat (60) @(posedge i_clk);
    stat(6, 1'b1);
    chk("pins taken", 1, o_crystal_pins_own);
    stat(7, 1'b0);
    i_periph_req_pin <= 1'b1;
    repeat (5) @(posedge i_clk);
    chk("pin input", 1, o_ext_pin_clock_input);
    stat(7, 1'b0);
    repeat (60) @(posedge i_clk);
    stat(7, 1'b1);
    for (int s = 1; s < 5; s++) begin
      uwr(8'h00, 8'(s % 4));
      act = s % 4;
      for (n = 0; n < 100 && o_main_source !== 2'(act); n++) @(posedge i_clk);
      chk("main source", act, o_main_source);
      stat(0, 1'b0);
    end
    uwr(8'h1c, 8'h01);
    chk("crystal drive", 1, o_crystal_drive_en);
    repeat (200) @(posedge i_clk);
    stat(6, 1'b0);
    repeat (100) @(posedge i_clk);
    stat(6, 1'b1);
    uwr(8'h02, 8'h01);
    uwr(8'h01, 8'h03);
    rd(8'h01, mdl[1]);
    chk("div locked", 1, o_periph_div);
    uwr(8'h11, 8'h2a);
    rd(8'h11, mdl[8'h11]);
    i_arst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    mdl[1] = 8'h11;
    mdl[2] = 0;
    lock = 0;
    win = 0;
    rd(8'h01, mdl[1]);
    rd(8'h02, 0);
    uwr(8'h01, 8'h03);
    rd(8'h01, mdl[1]);
    close_out();
  end
  initial begin
    repeat (40000) @(posedge i_clk);
    errors++;
    close_out();
  end
endmodule
